// >>> pfrl_pkg.sv
// package for the fault response block: command codes, field layout,
// reset values and timing counts.
// assumes a 100 MHz core clock.
package pfrl_pkg;
   localparam logic [7:0] CMD_INT_OT_RESP = 8'hD6;
   localparam logic [7:0] CMD_UV_RESP = 8'hD7;
   localparam logic [7:0] CMD_TON_RESP = 8'hD8;
   localparam logic [7:0] RST_INT_OT_RESP = 8'hC0;
   localparam logic [7:0] RST_UV_RESP = 8'hB8;
   localparam logic [7:0] RST_TON_RESP = 8'hB8;
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DLY_HI = 2;
   localparam int DLY_LO = 0;
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_DEGLITCH = 2'h1;
   localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
   localparam logic [1:0] RESP_WHILE = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_CONT = 3'h7;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 10;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   typedef enum logic [1:0] {
      PFRL_ST_RUN = 2'b00,
      PFRL_ST_DGL = 2'b01,
      PFRL_ST_OFF = 2'b10,
      PFRL_ST_WAIT = 2'b11
   } pfrl_state_t;
endpackage

// >>> pfrl_tick.sv
// free-running tick generator, one pulse every period cycles.
// assumes sys_clk_in at the package rate.
module pfrl_tick #(
   parameter int PERIOD = pfrl_pkg::TICK_CYC
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   output logic tick_out
);
   logic [15:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   always_comb begin
      tick_d = (cnt_q == 16'(PERIOD - 1));
      cnt_d = tick_d ? 16'h0000 : cnt_q + 16'h0001;
   end
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tick_out = tick_q;
endmodule

// >>> pfrl_chan.sv
// per-source response sequencer: deglitch, shutdown, retry, sticky flag.
// assumes fault_in is synchronous and already masked where needed.
module pfrl_chan (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic tick_in,
   input wire logic fault_in,
   input wire logic [7:0] setting_in,
   input wire logic enable_in,
   input wire logic clear_in,
   input wire logic retry_tick_in,
   output logic flag_out,
   output logic set_out,
   output logic off_out
);
   pfrl_pkg::pfrl_state_t st_q, st_d;
   logic [2:0] dly_q, dly_d;
   logic flag_q, flag_d;
   logic [1:0] resp;
   logic [2:0] retry;
   always_comb begin
      resp = setting_in[pfrl_pkg::RESP_HI:pfrl_pkg::RESP_LO];
      retry = setting_in[pfrl_pkg::RETRY_HI:pfrl_pkg::RETRY_LO];
      st_d = st_q;
      dly_d = dly_q;
      set_out = enable_in && fault_in && !flag_q;
      // set beats clear
      flag_d = set_out || (flag_q && !clear_in); // [RULE4] [RULE5]
      unique case (st_q)
         pfrl_pkg::PFRL_ST_RUN: begin
            dly_d = 3'h0;
            if (enable_in && fault_in) begin
               if (resp == pfrl_pkg::RESP_DEGLITCH) begin
                  st_d = pfrl_pkg::PFRL_ST_DGL; // [RULE2]
               end else if (resp == pfrl_pkg::RESP_SHUTDOWN) begin
                  st_d = pfrl_pkg::PFRL_ST_OFF; // [RULE3] [RULE14]
               end else if (resp == pfrl_pkg::RESP_WHILE) begin
                  st_d = pfrl_pkg::PFRL_ST_WAIT; // [RULE15]
               end
               // ignore code keeps regulating [RULE1]
            end
         end
         pfrl_pkg::PFRL_ST_DGL: begin
            if (!fault_in || !enable_in) begin
               st_d = pfrl_pkg::PFRL_ST_RUN; // restart count [RULE22]
            end else if (dly_q >= setting_in[pfrl_pkg::DLY_HI:0]) begin
               st_d = pfrl_pkg::PFRL_ST_OFF; // [RULE8]
            end else if (tick_in) begin
               dly_d = dly_q + 3'h1;
            end
         end
         pfrl_pkg::PFRL_ST_OFF: begin
            if (clear_in) begin
               st_d = pfrl_pkg::PFRL_ST_RUN; // [RULE6]
            end else if (retry == pfrl_pkg::RETRY_CONT && retry_tick_in) begin
               st_d = pfrl_pkg::PFRL_ST_RUN; // [RULE7] [RULE21]
            end
         end
         pfrl_pkg::PFRL_ST_WAIT: begin
            if (!fault_in) begin
               st_d = pfrl_pkg::PFRL_ST_RUN; // [RULE15]
            end
         end
      endcase
   end
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         st_q <= pfrl_pkg::PFRL_ST_RUN;
         dly_q <= 3'h0;
         flag_q <= 1'b0;
      end else begin
         st_q <= st_d;
         dly_q <= dly_d;
         flag_q <= flag_d;
      end
   end
   assign flag_out = flag_q;
   assign off_out = (st_q == pfrl_pkg::PFRL_ST_OFF) ||
                    (st_q == pfrl_pkg::PFRL_ST_WAIT);
endmodule

// >>> pfrl_top.sv
// Functional notes
// RULE1: code 00 keeps regulating, no action
// RULE2: code 01 runs for delay, then retry
// RULE3: code 10 disables output, then retry field
// RULE4: always set fault flag and alert unless masked
// RULE5: flag sticky until clear, off-on, restore, reset
// RULE6: retry 000 stays off until cleared
// RULE7: continuous retry spaced by retry interval
// RULE8: delay field counts 10us steps
// RULE9: turn-on-time fault sets other, vout, ton flags
// RULE10: turn-on-time setting zero disables response
// RULE11: internal overtemp byte at 0xD6, default 0xC0
// RULE12: internal overtemp sets other, mfr, ot flags
// RULE13: internal overtemp rejects codes 00 and 01
// RULE14: internal overtemp code 10 disables immediately
// RULE15: internal overtemp code 11 off while present
// RULE16: internal overtemp accepts only retry 000
// RULE17: internal overtemp ignores delay field
// RULE18: overtemp flag clears on clear, off-on, bias
// RULE19: unsupported write flags fault, keeps setting
// RULE20: mask undervoltage while channel inactive
// RULE21: continuous retry encoded as 111
// RULE22: deglitch count restarts when fault drops
//
// top of the fault response logic: command writes/reads of the three
// settings, three sequencers and the status flags.
// assumes a decoded command port from the serial front end.
module pfrl_top #(
   parameter int TICK_PERIOD = pfrl_pkg::TICK_CYC
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic cmd_wr_in,
   input wire logic cmd_rd_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic clear_faults_in,
   input wire logic restore_user_in,
   input wire logic device_reset_command_in,
   input wire logic output_on_in,
   input wire logic channel_active_in,
   input wire logic retry_interval_tick_in,
   input wire logic alert_mask_in,
   input wire logic uv_fault_in,
   input wire logic ton_fault_in,
   input wire logic ot_fault_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic cml_fault_out,
   output logic alert_out,
   output logic output_enable_out,
   output logic status_other_out,
   output logic status_word_vout_out,
   output logic status_word_mfr_out,
   output logic status_vout_uv_out,
   output logic status_vout_ton_out,
   output logic status_mfr_ot_out
);
   logic [7:0] uv_set_q, uv_set_d, ton_set_q, ton_set_d, ot_set_q, ot_set_d;
   logic [7:0] rd_q, rd_d;
   logic rdv_q, rdv_d, cml_q, cml_d, alert_q, alert_d, oen_q, oen_d;
   logic [5:0] stat_q, stat_d;
   logic on_q, on_d;
   logic tick, off_on, clr_all, clr_ot, uv_flt;
   logic uv_flag, ton_flag, ot_flag, uv_set, ton_set, ot_set;
   logic uv_off, ton_off, ot_off;
   logic [1:0] wr_resp;
   logic [2:0] wr_retry;
   logic bad_wr;

   pfrl_tick #(.PERIOD(TICK_PERIOD)) u_tick (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_out(tick)
   );

   always_comb begin
      off_on = output_on_in && !on_q;
      clr_ot = clear_faults_in || off_on; // [RULE18]
      clr_all = clr_ot || restore_user_in ||
                device_reset_command_in; // [RULE5]
      uv_flt = uv_fault_in && channel_active_in; // [RULE20]
   end

   pfrl_chan u_uv (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .fault_in(uv_flt),
      .setting_in(uv_set_q),
      .enable_in(1'b1),
      .clear_in(clr_all),
      .retry_tick_in(retry_interval_tick_in),
      .flag_out(uv_flag),
      .set_out(uv_set),
      .off_out(uv_off)
   );

   pfrl_chan u_ton (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .fault_in(ton_fault_in),
      .setting_in(ton_set_q),
      .enable_in(ton_set_q != 8'h00), // [RULE10]
      .clear_in(clr_all),
      .retry_tick_in(retry_interval_tick_in),
      .flag_out(ton_flag),
      .set_out(ton_set),
      .off_out(ton_off)
   );

   // overtemp has no retry and no delay, so those fields are masked off
   pfrl_chan u_ot (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .fault_in(ot_fault_in),
      .setting_in({ot_set_q[7:6], 6'h00}), // [RULE16] [RULE17]
      .enable_in(1'b1),
      .clear_in(clr_ot),
      .retry_tick_in(1'b0),
      .flag_out(ot_flag),
      .set_out(ot_set),
      .off_out(ot_off)
   );

   always_comb begin
      wr_resp = cmd_data_in[pfrl_pkg::RESP_HI:pfrl_pkg::RESP_LO];
      wr_retry = cmd_data_in[pfrl_pkg::RETRY_HI:pfrl_pkg::RETRY_LO];
      uv_set_d = uv_set_q;
      ton_set_d = ton_set_q;
      ot_set_d = ot_set_q;
      bad_wr = 1'b0;
      if (cmd_wr_in) begin
         unique case (cmd_code_in)
            pfrl_pkg::CMD_UV_RESP: begin
               bad_wr = (wr_resp == pfrl_pkg::RESP_WHILE) ||
                        (wr_retry != pfrl_pkg::RETRY_NONE &&
                         wr_retry != pfrl_pkg::RETRY_CONT);
               if (!bad_wr) begin
                  uv_set_d = cmd_data_in; // [RULE19]
               end
            end
            pfrl_pkg::CMD_TON_RESP: begin
               bad_wr = (wr_resp == pfrl_pkg::RESP_DEGLITCH) ||
                        (wr_resp == pfrl_pkg::RESP_WHILE) ||
                        (wr_retry != pfrl_pkg::RETRY_NONE &&
                         wr_retry != pfrl_pkg::RETRY_CONT);
               if (!bad_wr) begin
                  ton_set_d = cmd_data_in; // [RULE19]
               end
            end
            pfrl_pkg::CMD_INT_OT_RESP: begin
               bad_wr = (wr_resp == pfrl_pkg::RESP_IGNORE) ||
                        (wr_resp == pfrl_pkg::RESP_DEGLITCH) || // [RULE13]
                        (wr_retry != pfrl_pkg::RETRY_NONE); // [RULE16]
               if (!bad_wr) begin
                  ot_set_d = cmd_data_in; // [RULE19]
               end
            end
            default: bad_wr = 1'b0;
         endcase
      end
      // communication fault is sticky; a new bad write beats a clear
      cml_d = bad_wr || (cml_q && !clr_all);
      rdv_d = cmd_rd_in;
      rd_d = 8'h00;
      if (cmd_rd_in) begin
         unique case (cmd_code_in)
            pfrl_pkg::CMD_INT_OT_RESP: rd_d = ot_set_q; // [RULE11]
            pfrl_pkg::CMD_UV_RESP: rd_d = uv_set_q;
            pfrl_pkg::CMD_TON_RESP: rd_d = ton_set_q;
            default: rd_d = 8'h00;
         endcase
      end
   end

   always_comb begin
      // uv: other, vout word, uv; ton: other, vout word, ton [RULE9]
      // overtemp: other, mfr word, ot [RULE12]
      stat_d[0] = uv_flag || ton_flag || ot_flag || uv_set || ton_set ||
                  ot_set;
      stat_d[1] = uv_flag || ton_flag || uv_set || ton_set;
      stat_d[2] = ot_flag || ot_set;
      stat_d[3] = uv_flag || uv_set;
      stat_d[4] = ton_flag || ton_set;
      stat_d[5] = ot_flag || ot_set;
      alert_d = stat_d[0] && !alert_mask_in; // [RULE4]
      oen_d = output_on_in && !uv_off && !ton_off && !ot_off; // [RULE3]
      on_d = output_on_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         uv_set_q <= pfrl_pkg::RST_UV_RESP;
         ton_set_q <= pfrl_pkg::RST_TON_RESP;
         ot_set_q <= pfrl_pkg::RST_INT_OT_RESP; // [RULE11]
         rd_q <= 8'h00;
         rdv_q <= 1'b0;
         cml_q <= 1'b0;
         alert_q <= 1'b0;
         oen_q <= 1'b0;
         stat_q <= 6'h00;
         on_q <= 1'b0;
      end else begin
         uv_set_q <= uv_set_d;
         ton_set_q <= ton_set_d;
         ot_set_q <= ot_set_d;
         rd_q <= rd_d;
         rdv_q <= rdv_d;
         cml_q <= cml_d;
         alert_q <= alert_d;
         oen_q <= oen_d;
         stat_q <= stat_d;
         on_q <= on_d;
      end
   end

   assign rd_data_out = rd_q;
   assign rd_valid_out = rdv_q;
   assign cml_fault_out = cml_q;
   assign alert_out = alert_q;
   assign output_enable_out = oen_q;
   assign status_other_out = stat_q[0];
   assign status_word_vout_out = stat_q[1];
   assign status_word_mfr_out = stat_q[2];
   assign status_vout_uv_out = stat_q[3];
   assign status_vout_ton_out = stat_q[4];
   assign status_mfr_ot_out = stat_q[5];
endmodule

// >>> pfrl_checker.sv
// checker for pfrl_top: read answers, rejects, flags, shutdown, alert.
// assumes one clock domain and a bind onto every pfrl_top instance.
module pfrl_checker (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic cmd_wr_in,
   input wire logic cmd_rd_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic clear_faults_in,
   input wire logic output_on_in,
   input wire logic channel_active_in,
   input wire logic alert_mask_in,
   input wire logic uv_fault_in,
   input wire logic ton_fault_in,
   input wire logic ot_fault_in,
   input wire logic rd_valid_out,
   input wire logic cml_fault_out,
   input wire logic alert_out,
   input wire logic output_enable_out,
   input wire logic status_other_out,
   input wire logic status_vout_uv_out,
   input wire logic status_vout_ton_out,
   input wire logic status_mfr_ot_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   logic ot_wr;
   assign ot_wr = cmd_wr_in && cmd_code_in == pfrl_pkg::CMD_INT_OT_RESP;
   a_read_answer: assert property (cmd_rd_in |=> rd_valid_out)
      else $error("read not answered");
   a_ot_code_rej: assert property (ot_wr && !cmd_data_in[7] |=>
      cml_fault_out) else $error("bad overtemp code accepted");
   a_ot_retry_rej: assert property (ot_wr &&
      cmd_data_in[5:3] != 3'h0 |=> cml_fault_out)
      else $error("bad overtemp retry accepted");
   a_ot_flags: assert property (ot_fault_in |-> ##2
      status_mfr_ot_out && status_other_out) else $error("ot flags");
   a_ot_off: assert property (ot_fault_in |-> ##2
      !output_enable_out) else $error("output on in overtemp");
   a_alert_raise: assert property ((ot_fault_in && !alert_mask_in)
      ##1 !alert_mask_in [*2] |-> alert_out) else $error("no alert");
   a_alert_mask: assert property (alert_mask_in [*3] |->
      !alert_out) else $error("masked alert raised");
   a_uv_cause: assert property ($rose(status_vout_uv_out) |->
      $past(uv_fault_in) && $past(channel_active_in))
      else $error("uv flag without active fault");
   a_ton_cause: assert property ($rose(status_vout_ton_out) |->
      $past(ton_fault_in)) else $error("ton flag without fault");
   a_ot_sticky: assert property ($fell(status_mfr_ot_out) |->
      $past(clear_faults_in) || $past(clear_faults_in, 2) ||
      !$past(nrst_in) || ($past(output_on_in) && !$past(output_on_in, 2))
      || ($past(output_on_in, 2) && !$past(output_on_in, 3)))
      else $error("ot flag dropped without clear");
endmodule
bind pfrl_top pfrl_checker i_chk (.*);

// >>> pfrl_host.sv
// host model: single-byte command writes and reads on the command port.
// assumes its tasks are called after reset release.
module pfrl_host (
   input wire logic sys_clk_in,
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_data_in,
   output logic cmd_wr_out,
   output logic cmd_rd_out,
   output logic [7:0] cmd_code_out,
   output logic [7:0] cmd_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_wr_out = 1'b0;
      cmd_rd_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_data_out = 8'h00;
   end
   task automatic wr(input logic [7:0] code, input logic [7:0] dat);
      @(posedge sys_clk_in);
      cmd_code_out <= code;
      cmd_data_out <= dat;
      cmd_wr_out <= 1'b1;
      @(posedge sys_clk_in);
      cmd_wr_out <= 1'b0;
   endtask
   // a lost answer returns unknowns so the bench comparison fails
   task automatic rd(input logic [7:0] code, output logic [7:0] dat);
      dat = 8'hxx;
      @(posedge sys_clk_in);
      cmd_code_out <= code;
      cmd_rd_out <= 1'b1;
      @(posedge sys_clk_in);
      cmd_rd_out <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(negedge sys_clk_in);
         if (rd_valid_in === 1'b1) begin
            dat = rd_data_in;
            break;
         end
      end
   endtask
endmodule

// >>> pfrl_top_tb.sv
// self-checking bench for pfrl_top driven through the host model.
// assumes a shortened tick period so deglitch delays stay short.
module pfrl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
 $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
   logic clk = 0, nrst = 0, clr = 0, rsto = 0, drst = 0, on = 1, act = 1;
   logic rtk = 0, msk = 0, uv = 0, ton = 0, ot = 0;
   logic wr, rd, rdv, cml, alert, oe, s_o, s_v, s_m, s_u, s_t, s_ot;
   logic [7:0] code, data, rdd, d;
   int num_errors = 0, n_checks = 0;
   pfrl_host i_host (.sys_clk_in(clk), .rd_valid_in(rdv), .rd_data_in(rdd),
      .cmd_wr_out(wr), .cmd_rd_out(rd), .cmd_code_out(code),
      .cmd_data_out(data));
   pfrl_top #(.TICK_PERIOD(8)) i_dut (.sys_clk_in(clk), .nrst_in(nrst),
      .cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_code_in(code),
      .cmd_data_in(data), .clear_faults_in(clr), .restore_user_in(rsto),
      .device_reset_command_in(drst), .output_on_in(on),
      .channel_active_in(act), .retry_interval_tick_in(rtk),
      .alert_mask_in(msk), .uv_fault_in(uv), .ton_fault_in(ton),
      .ot_fault_in(ot), .rd_data_out(rdd), .rd_valid_out(rdv),
      .cml_fault_out(cml), .alert_out(alert), .output_enable_out(oe),
      .status_other_out(s_o), .status_word_vout_out(s_v),
      .status_word_mfr_out(s_m), .status_vout_uv_out(s_u),
      .status_vout_ton_out(s_t), .status_mfr_ot_out(s_ot));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic ng(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      ng(3);
   endtask
   task automatic t_ot_rej();
      i_host.rd(pfrl_pkg::CMD_INT_OT_RESP, d);
      `CHK(d, 8'hC0)
      i_host.wr(pfrl_pkg::CMD_INT_OT_RESP, 8'h40);
      ng(1);
      `CHK(cml, 1'b1)
      i_host.rd(pfrl_pkg::CMD_INT_OT_RESP, d);
      `CHK(d, 8'hC0)
      clear();
      i_host.wr(pfrl_pkg::CMD_INT_OT_RESP, 8'h88);
      ng(1);
      `CHK(cml, 1'b1)
      clear();
   endtask
   task automatic t_ot_while();
      i_host.wr(pfrl_pkg::CMD_INT_OT_RESP, 8'hC7);
      ng(1);
      `CHK(cml, 1'b0)
      @(posedge clk) ot <= 1'b1;
      ng(4);
      `CHK({oe, s_o, s_m, s_ot, alert}, 5'h0F)
      @(posedge clk) ot <= 1'b0;
      ng(4);
      `CHK({oe, s_ot}, 2'b11)
      @(posedge clk) rsto <= 1'b1;
      @(posedge clk) rsto <= 1'b0;
      ng(3);
      `CHK(s_ot, 1'b1)
      clear();
      `CHK(s_ot, 1'b0)
      i_host.wr(pfrl_pkg::CMD_INT_OT_RESP, 8'h80);
      ng(1);
      `CHK(cml, 1'b0)
      @(posedge clk) ot <= 1'b1;
      ng(4);
      `CHK(oe, 1'b0)
      @(posedge clk) ot <= 1'b0;
      ng(4);
      `CHK({oe, s_ot}, 2'b01)
      clear();
      `CHK(oe, 1'b1)
   endtask
   task automatic t_uv();
      i_host.wr(pfrl_pkg::CMD_UV_RESP, 8'h00);
      @(posedge clk) uv <= 1'b1;
      ng(4);
      `CHK({oe, s_o, s_v, s_u, alert}, 5'h1F)
      @(posedge clk) msk <= 1'b1;
      ng(3);
      `CHK(alert, 1'b0)
      @(posedge clk) uv <= 1'b0;
      msk <= 1'b0;
      drst <= 1'b1;
      @(posedge clk) drst <= 1'b0;
      ng(3);
      `CHK(s_u, 1'b0)
      // delay 7: two 40-cycle fault spans split by one clean cycle
      i_host.wr(pfrl_pkg::CMD_UV_RESP, 8'h47);
      @(posedge clk) uv <= 1'b1;
      ng(40);
      @(posedge clk) uv <= 1'b0;
      @(posedge clk) uv <= 1'b1;
      ng(40);
      `CHK(oe, 1'b1)
      @(posedge clk) uv <= 1'b0;
      // code 01, no retry, two ticks of delay
      i_host.wr(pfrl_pkg::CMD_UV_RESP, 8'h42);
      @(posedge clk) uv <= 1'b1;
      ng(4);
      `CHK(oe, 1'b1)
      ng(20);
      `CHK(oe, 1'b0)
      @(posedge clk) uv <= 1'b0;
      rtk <= 1'b1;
      @(posedge clk) rtk <= 1'b0;
      ng(4);
      `CHK(oe, 1'b0)
      clear();
      i_host.wr(pfrl_pkg::CMD_UV_RESP, 8'hB8);
      @(posedge clk) uv <= 1'b1;
      ng(4);
      `CHK(oe, 1'b0)
      @(posedge clk) uv <= 1'b0;
      rtk <= 1'b1;
      @(posedge clk) rtk <= 1'b0;
      ng(4);
      `CHK(oe, 1'b1)
      @(posedge clk) on <= 1'b0;
      @(posedge clk) on <= 1'b1;
      ng(4);
      `CHK(s_u, 1'b0)
      @(posedge clk) act <= 1'b0;
      uv <= 1'b1;
      ng(4);
      `CHK({oe, s_u}, 2'b10)
      @(posedge clk) uv <= 1'b0;
      act <= 1'b1;
   endtask
   task automatic t_ton();
      i_host.wr(pfrl_pkg::CMD_TON_RESP, 8'h00);
      @(posedge clk) ton <= 1'b1;
      ng(4);
      `CHK({s_t, oe}, 2'b01)
      @(posedge clk) ton <= 1'b0;
      i_host.wr(pfrl_pkg::CMD_TON_RESP, 8'h80);
      @(posedge clk) ton <= 1'b1;
      ng(4);
      `CHK({s_o, s_v, s_t, oe}, 4'hE)
      @(posedge clk) ton <= 1'b0;
      clear();
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      ng(3);
      `CHK(oe, 1'b1)
      t_ot_rej();
      t_ot_while();
      t_uv();
      t_ton();
      end_sim();
   end
endmodule
